//--- hdl/pmi_params.svh
/*
 Constants for the two-wire register target: address, register count, timing.
 Assumes inclusion by the package and design file only.
*/
`ifndef PMI_PARAMS_SVH
`define PMI_PARAMS_SVH
`define PMI_TARGET_ADDR 7'h08
`define PMI_GENERAL_CALL 7'h00
`define PMI_CLK_HZ 25000000
`define PMI_MAX_BIT_RATE 400000
`define PMI_MIN_CLK_PER_BIT (`PMI_CLK_HZ / `PMI_MAX_BIT_RATE)
`define PMI_REG_COUNT 256
`endif

//--- hdl/pmi_pkg.sv
/*
 Types for the two-wire register target.
 Assumes the params header is on the include path.
*/
`include "pmi_params.svh"
package pmi_pkg;
   typedef enum logic [2:0] {
      st_idle,
      st_addr,
      st_reg,
      st_data,
      st_read,
      st_read_ack,
      st_ignore
   } pmi_state_type;
   typedef logic [7:0] pmi_byte_type;
endpackage

//--- hdl/pmi_target.sv
/*
 Two-wire bus target giving a controller access to the device register set.
 Assumes bus clock and data arrive asynchronously; the bench resolves the open-drain wire.
*/
`timescale 1ns/1ps
`include "pmi_params.svh"
module pmi_target #(
   parameter int REG_COUNT = `PMI_REG_COUNT
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   output logic scl_out,
   output logic scl_oe_n,
   output logic busy,
   output logic [7:0] wr_index,
   output logic [7:0] wr_data,
   output logic wr_strobe
);
   import pmi_pkg::*;

   logic [7:0] regs [0:REG_COUNT-1];
   logic scl_meta, scl_sync, scl_prev;
   logic sda_meta, sda_sync, sda_prev;
   logic scl_rise, scl_fall, start_seen, stop_seen;
   pmi_state_type state;
   logic [7:0] shift;
   logic [3:0] bit_cnt;
   logic [7:0] reg_ptr;
   logic rw;
   logic ack_phase;
   logic ack_drive;
   logic tx_bit;
   logic [7:0] tx_byte;

   // two-flop synchronisers; first flops read by nothing else
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         scl_meta <= 1'b1;
         scl_sync <= 1'b1;
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
      end else begin
         scl_meta <= scl_in;
         scl_sync <= scl_meta;
         sda_meta <= sda_in;
         sda_sync <= sda_meta;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_prev <= scl_sync;
         sda_prev <= sda_sync;
      end
   end

   // 25 MHz gives over 60 samples per 400 kbit/s bit, so edge sampling holds
   assign scl_rise = scl_sync && !scl_prev;
   assign scl_fall = !scl_sync && scl_prev;
   assign start_seen = scl_sync && scl_prev && sda_prev && !sda_sync;
   assign stop_seen = scl_sync && scl_prev && !sda_prev && sda_sync;

   // target only: clock line is never pulled, no stretching
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         scl_out <= 1'b0;
         scl_oe_n <= 1'b1;
      end else begin
         scl_out <= 1'b0;
         scl_oe_n <= 1'b1;
      end
   end

   // address decode: seven-bit compare only, general call never matches
   function automatic logic addr_match(input logic [7:0] b);
      return (b[7:1] == `PMI_TARGET_ADDR) && (b[7:1] != `PMI_GENERAL_CALL);
   endfunction

   // states that take a byte in from the controller
   function automatic logic is_rx(input pmi_state_type s);
      return (s == st_addr) || (s == st_reg) || (s == st_data);
   endfunction

   // states in which the data line is left alone
   function automatic logic is_parked(input pmi_state_type s);
      return (s == st_idle) || (s == st_ignore);
   endfunction

   logic quiet;
   logic rx_bit;
   logic byte_done;
   logic ack_end;
   logic rd_load;
   logic rd_fall;

   // start and stop win over every bit event of the same cycle
   assign quiet = !stop_seen && !start_seen;
   assign rx_bit = quiet && is_rx(state) && scl_rise && !ack_phase;
   assign byte_done = quiet && is_rx(state) && scl_fall && !ack_phase && (bit_cnt == 4'h8);
   assign ack_end = quiet && is_rx(state) && scl_fall && ack_phase;
   assign rd_load = ack_end && (state == st_addr) && rw;
   assign rd_fall = quiet && (state == st_read) && scl_fall;

   // protocol state
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state <= st_idle;
      end else if (stop_seen) begin
         state <= st_idle;
      end else if (start_seen) begin
         // a repeated start keeps reg_ptr for the read phase
         state <= st_addr;
      end else begin
         case (state)
            st_idle: begin
               state <= st_idle;
            end
            st_ignore: begin
               state <= st_ignore;
            end
            st_addr: begin
               if (byte_done && !addr_match(shift)) begin
                  state <= st_ignore;
               end else if (ack_end) begin
                  state <= rw ? st_read : st_reg;
               end
            end
            st_reg: begin
               if (ack_end) begin
                  state <= st_data;
               end
            end
            st_data: begin
               // no auto-increment: further bytes are not acknowledged
               if (ack_end) begin
                  state <= st_ignore;
               end
            end
            st_read: begin
               if (rd_fall && (bit_cnt == 4'h8)) begin
                  state <= st_read_ack;
               end
            end
            st_read_ack: begin
               // one byte only; any answer ends our part, stop expected
               if (scl_rise) begin
                  state <= st_ignore;
               end
            end
            default: begin
               state <= st_idle;
            end
         endcase
      end
   end

   // bit counter, shared by receive and send
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         bit_cnt <= 4'h0;
      end else if (start_seen && !stop_seen) begin
         bit_cnt <= 4'h0;
      end else if (byte_done) begin
         bit_cnt <= 4'h0;
      end else if (rx_bit) begin
         bit_cnt <= bit_cnt + 4'h1;
      end else if (rd_load) begin
         // first read bit is placed by the load itself
         bit_cnt <= 4'h1;
      end else if (rd_fall && (bit_cnt != 4'h8)) begin
         bit_cnt <= bit_cnt + 4'h1;
      end
   end

   // receive shifter, sampled on clock rise
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         shift <= 8'h00;
      end else if (rx_bit) begin
         shift <= {shift[6:0], sda_sync};
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ack_phase <= 1'b0;
      end else if (!quiet) begin
         ack_phase <= 1'b0;
      end else if (byte_done) begin
         ack_phase <= 1'b1;
      end else if (ack_end) begin
         ack_phase <= 1'b0;
      end
   end

   // acknowledge drive for the ninth clock
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ack_drive <= 1'b0;
      end else if (!quiet) begin
         ack_drive <= 1'b0;
      end else if (byte_done) begin
         if ((state != st_addr) || addr_match(shift)) begin
            ack_drive <= 1'b1;
         end
      end else if (ack_end) begin
         ack_drive <= 1'b0;
      end else if (is_parked(state)) begin
         ack_drive <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rw <= 1'b0;
         reg_ptr <= 8'h00;
      end else if (byte_done && (state == st_addr) && addr_match(shift)) begin
         rw <= shift[0];
      end else if (byte_done && (state == st_reg)) begin
         reg_ptr <= shift;
      end
   end

   // send path: bit changes only while the clock is low
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tx_bit <= 1'b1;
         tx_byte <= 8'h00;
      end else if (!quiet) begin
         tx_bit <= 1'b1;
      end else if (rd_load) begin
         tx_byte <= regs[reg_ptr];
         tx_bit <= regs[reg_ptr][7];
      end else if (rd_fall) begin
         if (bit_cnt == 4'h8) begin
            tx_bit <= 1'b1; // release for controller ack slot
         end else begin
            tx_bit <= tx_byte[3'(7 - bit_cnt)];
         end
      end else if (is_parked(state)) begin
         tx_bit <= 1'b1;
      end
   end

   // register array is not reset: a read before any write returns unknown
   always_ff @(posedge clk) begin
      if (reset_n && byte_done && (state == st_data)) begin
         regs[reg_ptr] <= shift;
      end
   end

   // single data byte: write shown on the ports at the data byte's end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wr_strobe <= 1'b0;
         wr_index <= 8'h00;
         wr_data <= 8'h00;
      end else begin
         wr_strobe <= byte_done && (state == st_data);
         if (byte_done && (state == st_data)) begin
            wr_index <= reg_ptr;
            wr_data <= shift;
         end
      end
   end

   // data line: open drain, oe_n low while pulling low
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sda_out <= 1'b0;
         sda_oe_n <= 1'b1;
      end else begin
         sda_out <= 1'b0;
         sda_oe_n <= !(ack_drive || (state == st_read && !tx_bit));
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         busy <= 1'b0;
      end else begin
         busy <= (state != st_idle) && (state != st_ignore);
      end
   end

endmodule // pmi_target

//--- verif/pmi_chk.sv
/* checker for the two-wire register target, bound to its ports
   assumes scl_in is the resolved bus clock wire */
`timescale 1ns/1ps
module pmi_chk (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   input wire logic scl_out,
   input wire logic scl_oe_n,
   input wire logic busy,
   input wire logic [7:0] wr_index,
   input wire logic [7:0] wr_data,
   input wire logic wr_strobe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_clock_never_driven: assert property (scl_oe_n)
      else $error("clock line driven");
   a_clock_out_low: assert property (!scl_out)
      else $error("clock output level not low");
   a_data_pull_only: assert property (!sda_oe_n |-> !sda_out)
      else $error("data line driven high");
   a_data_on_low: assert property ($changed(sda_oe_n) |-> !scl_in)
      else $error("data changed while clock high");
   a_drive_needs_busy: assert property (!sda_oe_n |-> ##[0:4] busy)
      else $error("data driven outside addressed transfer");
   a_drive_released: assert property ($fell(sda_oe_n) |-> ##[1:600] sda_oe_n)
      else $error("data line held too long");
   a_strobe_single: assert property (wr_strobe |=> !wr_strobe)
      else $error("write strobe longer than a cycle");
   a_strobe_in_xfer: assert property (wr_strobe |-> busy && !scl_in)
      else $error("write strobe outside data byte end");
   a_write_hold: assert property (!wr_strobe |-> $stable(wr_data) && $stable(wr_index))
      else $error("write value moved without strobe");
endmodule // pmi_chk
bind pmi_target pmi_chk u_chk (.clk(clk), .reset_n(reset_n), .scl_in(scl_in), .sda_out(sda_out),
   .sda_oe_n(sda_oe_n), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .busy(busy), .wr_index(wr_index),
   .wr_data(wr_data),
   .wr_strobe(wr_strobe));

//--- verif/pmi_ctl.sv
/* bus controller model: start, stop, byte out, byte in
   assumes the bench resolves the open-drain data wire into sda */
`timescale 1ns/1ps
module pmi_ctl #(parameter int Q = 16) (
   input wire logic clk,
   input wire logic sda,
   output logic scl_m,
   output logic sda_m
);
   initial begin
      scl_m = 1'b1;
      sda_m = 1'b1;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   // bit period 4*Q clocks, slower than fast mode allows
   task automatic bit_x(input logic b, output logic s);
      scl_m <= 1'b0;
      wt(Q);
      sda_m <= b;
      wt(Q);
      scl_m <= 1'b1;
      wt(Q);
      s = sda;
      wt(Q);
   endtask
   // clock dropped first so a driven ack never turns into a stop
   task automatic start;
      scl_m <= 1'b0;
      wt(Q);
      sda_m <= 1'b1;
      wt(Q);
      scl_m <= 1'b1;
      wt(Q);
      sda_m <= 1'b0;
      wt(Q);
   endtask
   task automatic stop;
      scl_m <= 1'b0;
      wt(Q);
      sda_m <= 1'b0;
      wt(Q);
      scl_m <= 1'b1;
      wt(Q);
      sda_m <= 1'b1;
      wt(2 * Q);
   endtask
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_x(b[i], s);
      bit_x(1'b1, s);
      ack = !s;
   endtask
   task automatic rbyte(output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
      bit_x(1'b1, s);
   endtask
endmodule // pmi_ctl

//--- verif/tb.sv
/* bench for the two-wire register target
   assumes pull-ups on both wires, resolved here */
`timescale 1ns/1ps
module tb;
   import pmi_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic scl_m, sda_m, sda_out, sda_oe_n, scl_out, scl_oe_n, busy, wr_strobe;
   logic [7:0] wr_index, wr_data;
   int bad_count = 0;
   int comparisons = 0;
   int strobes = 0;
   int cyc = 0;
   wire logic sda_w = sda_m & (sda_oe_n | sda_out);
   wire logic scl_w = scl_m & (scl_oe_n | scl_out);
   always #20 clk = ~clk;
   pmi_ctl ctl (.clk(clk), .sda(sda_w), .scl_m(scl_m), .sda_m(sda_m));
   pmi_target DUT (.clk(clk), .reset_n(reset_n), .scl_in(scl_w), .sda_in(sda_w), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .busy(busy),
      .wr_index(wr_index), .wr_data(wr_data), .wr_strobe(wr_strobe));
   always @(posedge clk) begin
      strobes <= strobes + (wr_strobe === 1'b1);
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         bad_count++;
         end_sim;
      end
   end
   task automatic end_sim;
      if (bad_count == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic c, input string m);
      comparisons++;
      if (c !== 1'b1) begin
         bad_count++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task automatic wr(input pmi_byte_type r, d, output logic a);
      logic a0, a1, a2;
      ctl.start;
      ctl.wbyte(8'h10, a0);
      ctl.wbyte(r, a1);
      ctl.wbyte(d, a2);
      ctl.stop;
      a = a0 & a1 & a2;
   endtask
   task automatic t_write_read;
      pmi_byte_type q;
      logic a, a0, a1, a2;
      int n0;
      for (int i = 0; i < 2; i++) begin
         n0 = strobes;
         wr(i ? 8'hFF : 8'h00, i ? 8'h5A : 8'hA5, a);
         chk(a === 1'b1, "write not acked");
         chk(strobes === n0 + 1 && wr_index === (i ? 8'hFF : 8'h00), "write index");
         chk(wr_data === (i ? 8'h5A : 8'hA5), "write data");
         ctl.start;
         ctl.wbyte(8'h10, a0);
         ctl.wbyte(i ? 8'hFF : 8'h00, a1);
         ctl.start;
         ctl.wbyte(8'h11, a2);
         ctl.rbyte(q);
         ctl.stop;
         chk(a0 & a1 & a2 && q === (i ? 8'h5A : 8'hA5), "read back");
      end
   endtask
   task automatic t_refuse;
      logic a;
      pmi_byte_type bad [3] = '{8'h12, 8'h00, 8'hF0};
      for (int i = 0; i < 3; i++) begin
         ctl.start;
         ctl.wbyte(bad[i], a);
         chk(a === 1'b0 && busy === 1'b0, "foreign address acked");
         ctl.stop;
      end
      wr(8'h21, 8'h3C, a);
      chk(a === 1'b1 && wr_data === 8'h3C, "retry failed");
   endtask
   task automatic t_single;
      logic a0, a1, a2, a3;
      int n0;
      n0 = strobes;
      ctl.start;
      ctl.wbyte(8'h10, a0);
      ctl.wbyte(8'h40, a1);
      ctl.wbyte(8'h77, a2);
      ctl.wbyte(8'h99, a3);
      ctl.stop;
      chk(a2 === 1'b1 && a3 === 1'b0, "second data byte acked");
      chk(strobes === n0 + 1 && wr_data === 8'h77 && wr_index === 8'h40, "burst wrote");
   endtask
   initial begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_write_read;
      t_refuse;
      t_single;
      end_sim;
   end
endmodule // tb
